// ===== hdl/dac_update_and_reset_control.sv
// DAC update, clear and reset sequencing with parallel and serial write paths.
// Assumes every pin input is asynchronous to mclk_i and the serial clock is far slower.
// Functional notes
// - Six address pins pick one of 40 channels.
// - Register select steers data, offset, gain, special.
// - Serial output changes on rising serial clock.
// - Toggle mode: A/B pin picks write target.
// - Without toggle mode, writes go to A.
// - Toggle mode: load switches outputs between A/B.
// - Busy low while computing; no output update.
// - Load while not busy updates outputs.
// - Load during calculation is stored, applied later.
// - Busy low in reset; loads discarded.
// - Clear falling edge loads clear code everywhere.
// - Clear holds busy low 35 us.
// - Reset falling edge restores power-on register defaults, except the clear code register.
// - Reset sequence 270 us, busy low, interfaces off; the serial readback output and its enable still follow the serial pins.
// - After reset, reset level ignored until edge.
// - Serial data shifts in on falling clock.
`include "dac_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dac_update_and_reset_control
	import dac_ctrl_pkg::*;
#(
	parameter int RESET_CYCLES = `RST_CYCLES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Parallel interface
	input wire chan_t channel_address_i,
	input wire logic [1:0] register_select_i,
	input wire code_t data_i,
	input wire logic cs_n_i,
	input wire logic wr_n_i,
	input wire logic ser_par_i,
	input wire logic ab_select_i,
	input wire logic toggle_mode_i,
	// Control strobes
	input wire logic load_outputs_strobe_n_i,
	input wire logic clear_input_n_i,
	input wire logic reset_n_i,
	// Serial interface
	input wire logic sclk_i,
	input wire logic sdin_i,
	input wire logic sync_n_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_n_o,
	// Status and DAC codes
	output logic busy_n_o,
	output logic dac_update_o,
	output code_t [`NUM_CH-1:0] dac_out_o
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	pins_s pin_raw;
	pins_s pin_s1_reg;
	pins_s pin_s2_reg;
	pins_s pin_s3_reg;

	assign pin_raw = '{addr: channel_address_i, sel: reg_sel_e'(register_select_i),
		data: data_i, cs_n: cs_n_i, wr_n: wr_n_i, ser: ser_par_i, ab: ab_select_i,
		ld_n: load_outputs_strobe_n_i, clr_n: clear_input_n_i, rst_n: reset_n_i,
		sclk: sclk_i, sdin: sdin_i, sync_n: sync_n_i, toggle: toggle_mode_i};

	// Idle levels at reset so no false edge is seen on release
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1_reg <= '{default: 1'b1, addr: '0, sel: SEL_SFR, data: '0, sclk: 1'b0};
			pin_s2_reg <= '{default: 1'b1, addr: '0, sel: SEL_SFR, data: '0, sclk: 1'b0};
			pin_s3_reg <= '{default: 1'b1, addr: '0, sel: SEL_SFR, data: '0, sclk: 1'b0};
		end else begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	function automatic logic fell(input logic prev, input logic now);
		return prev & ~now;
	endfunction

	wire logic reset_fall = fell(pin_s3_reg.rst_n, pin_s2_reg.rst_n);
	wire logic ld_fall = fell(pin_s3_reg.ld_n, pin_s2_reg.ld_n);
	wire logic clr_fall = fell(pin_s3_reg.clr_n, pin_s2_reg.clr_n);
	wire logic sclk_fall = fell(pin_s3_reg.sclk, pin_s2_reg.sclk);
	wire logic sclk_rise = fell(pin_s2_reg.sclk, pin_s3_reg.sclk);
	wire logic wr_rise = fell(pin_s2_reg.wr_n, pin_s3_reg.wr_n);
	wire logic sync_rise = fell(pin_s2_reg.sync_n, pin_s3_reg.sync_n);
	wire logic toggle = pin_s2_reg.toggle;
	wire logic ser_mode = pin_s2_reg.ser;

	// ****************************************
	// Write decode
	// ****************************************
	state_e state_reg;
	state_e state_next;
	cnt_t cnt_reg;
	cnt_t cnt_next;
	logic pending_reg;
	logic pending_next;
	logic out_b_reg;
	logic [`FRAME_BITS-1:0] shift_reg;
	code_t data_a_reg [`NUM_CH];
	code_t data_b_reg [`NUM_CH];
	code_t offset_reg [`NUM_CH];
	code_t gain_reg [`NUM_CH];
	code_t clr_code_reg;

	wire logic blocked = (state_reg == ST_RESET) | reset_fall;
	wire logic par_wr = ~ser_mode & ~pin_s2_reg.cs_n & wr_rise;
	wire logic ser_wr = ser_mode & sync_rise;
	wire logic wr_go = (par_wr | ser_wr) & ~blocked;
	wire wr_req_s req = ser_mode ?
		wr_req_s'{ab: shift_reg[`FR_AB], sel: reg_sel_e'(shift_reg[`FR_SEL_HI:`FR_SEL_LO]),
		chan: shift_reg[`FR_CH_HI:`FR_CH_LO], data: shift_reg[`FR_DAT_HI:`FR_DAT_LO]} :
		wr_req_s'{ab: pin_s2_reg.ab, sel: pin_s2_reg.sel, chan: pin_s2_reg.addr,
		data: pin_s2_reg.data};
	wire logic chan_ok = req.chan < 6'(`NUM_CH);
	wire logic wr_ch = wr_go & chan_ok;
	wire logic data_wr = wr_ch & (req.sel == SEL_DATA);
	wire logic wr_to_b = req.ab & toggle;
	wire logic clr_code_wr = wr_go & (req.sel == SEL_SFR) & (req.chan == `SFR_CLRCODE);
	wire logic show_b = toggle & out_b_reg;

	// ****************************************
	// Sequencer
	// ****************************************
	wire logic cnt_done = (cnt_reg == '0);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_done ? cnt_reg : cnt_reg - 14'h0001;
		if (reset_fall) begin
			state_next = ST_RESET;
			cnt_next = cnt_t'(RESET_CYCLES - 1);
		end else begin
			case (state_reg)
				ST_RESET: begin
					if (cnt_done) begin
						state_next = ST_IDLE;
					end
				end
				ST_IDLE, ST_CALC: begin
					if (clr_fall) begin
						state_next = ST_CLEAR;
						cnt_next = cnt_t'(`CLR_CYCLES - 1);
					end else if (data_wr) begin
						state_next = ST_CALC;
						cnt_next = cnt_t'(`CALC_CYCLES - 1);
					end else if (cnt_done) begin
						state_next = ST_IDLE;
					end
				end
				ST_CLEAR: begin
					if (cnt_done) begin
						state_next = ST_IDLE;
					end
				end
				default: begin
					state_next = ST_RESET;
					cnt_next = cnt_t'(RESET_CYCLES - 1);
				end
			endcase
		end
	end

	// Loads straight from idle, or a stored one as busy ends
	wire logic load_now = ld_fall & (state_reg == ST_IDLE) & (state_next == ST_IDLE);
	wire logic flush = pending_reg & (state_reg != ST_RESET) & (state_next == ST_IDLE);
	wire logic do_update = load_now | flush;

	// A new load wins over the flush that would clear the stored one
	always_comb begin
		pending_next = pending_reg;
		if (blocked) begin
			pending_next = 1'b0;
		end else if (ld_fall & ~load_now) begin
			pending_next = 1'b1;
		end else if (flush) begin
			pending_next = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_RESET;
			cnt_reg <= cnt_t'(RESET_CYCLES - 1);
			pending_reg <= 1'b0;
			out_b_reg <= 1'b0;
			busy_n_o <= 1'b0;
			dac_update_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			pending_reg <= pending_next;
			out_b_reg <= blocked ? 1'b0 : (do_update ? ~show_b & toggle : out_b_reg);
			busy_n_o <= (state_next == ST_IDLE);
			dac_update_o <= do_update;
		end
	end

	// ****************************************
	// Serial shifter and readback
	// ****************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_reg <= '0;
			serial_data_out_o <= 1'b0;
			serial_data_out_oe_n_o <= 1'b1;
		end else begin
			if (ser_mode & ~pin_s2_reg.sync_n & sclk_fall & ~blocked) begin
				shift_reg <= {shift_reg[`FRAME_BITS-2:0], pin_s2_reg.sdin};
			end
			if (sclk_rise) begin
				serial_data_out_o <= shift_reg[`FRAME_BITS-1];
			end
			serial_data_out_oe_n_o <= ~(ser_mode & ~pin_s2_reg.sync_n);
		end
	end

	// ****************************************
	// Channel registers
	// ****************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `NUM_CH; i++) begin
				data_a_reg[i] <= `DATA_RST;
				data_b_reg[i] <= `DATA_RST;
				offset_reg[i] <= `OFFSET_RST;
				gain_reg[i] <= `GAIN_RST;
				dac_out_o[i] <= `DATA_RST;
			end
			clr_code_reg <= `CLRCODE_RST;
		end else if (reset_fall) begin
			for (int i = 0; i < `NUM_CH; i++) begin
				data_a_reg[i] <= `DATA_RST;
				data_b_reg[i] <= `DATA_RST;
				offset_reg[i] <= `OFFSET_RST;
				gain_reg[i] <= `GAIN_RST;
				dac_out_o[i] <= `DATA_RST;
			end
		end else begin
			if (data_wr & wr_to_b) begin
				data_b_reg[req.chan] <= req.data;
			end
			if (data_wr & ~wr_to_b) begin
				data_a_reg[req.chan] <= req.data;
			end
			if (wr_ch & (req.sel == SEL_OFFSET)) begin
				offset_reg[req.chan] <= req.data;
			end
			if (wr_ch & (req.sel == SEL_GAIN)) begin
				gain_reg[req.chan] <= req.data;
			end
			if (clr_code_wr) begin
				clr_code_reg <= req.data;
			end
			for (int i = 0; i < `NUM_CH; i++) begin
				if (clr_fall & (state_next == ST_CLEAR)) begin
					dac_out_o[i] <= clr_code_reg;
				end else if (do_update) begin
					dac_out_o[i] <= show_b ? data_b_reg[i] : data_a_reg[i];
				end
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_reset_busy;
		@(posedge mclk_i) disable iff (rst_i)
		reset_fall |=> !busy_n_o [*8];
	endproperty
	a_reset_busy: assert property (p_reset_busy) else $error("busy high in reset");

	property p_reset_level;
		@(posedge mclk_i) disable iff (rst_i)
		(state_reg == ST_IDLE) && !pin_s2_reg.rst_n && !reset_fall |=> state_reg != ST_RESET;
	endproperty
	a_reset_level: assert property (p_reset_level) else $error("reset level restarted");

	property p_drop_pending;
		@(posedge mclk_i) disable iff (rst_i)
		reset_fall |=> !pending_reg && !dac_update_o;
	endproperty
	a_drop_pending: assert property (p_drop_pending) else $error("load kept over reset");

	property p_clear_busy;
		@(posedge mclk_i) disable iff (rst_i)
		clr_fall && (state_reg == ST_IDLE) && !reset_fall |=> !busy_n_o [*8];
	endproperty
	a_clear_busy: assert property (p_clear_busy) else $error("busy high in clear");

	property p_clear_load;
		@(posedge mclk_i) disable iff (rst_i)
		clr_fall && (state_reg == ST_IDLE) && !reset_fall |=>
			dac_out_o[5] == $past(clr_code_reg);
	endproperty
	a_clear_load: assert property (p_clear_load) else $error("clear code not loaded");

	property p_load_idle;
		@(posedge mclk_i) disable iff (rst_i)
		load_now && !toggle |=> dac_update_o && (dac_out_o[0] == $past(data_a_reg[0]));
	endproperty
	a_load_idle: assert property (p_load_idle) else $error("load not applied");

	property p_no_update_calc;
		@(posedge mclk_i) disable iff (rst_i)
		ld_fall && (state_reg == ST_CALC) && !cnt_done && !reset_fall |=>
			!dac_update_o && pending_reg;
	endproperty
	a_no_update_calc: assert property (p_no_update_calc) else $error("update while busy");

	property p_flush;
		@(posedge mclk_i) disable iff (rst_i)
		pending_reg && (state_reg == ST_CALC) && cnt_done && !reset_fall && !clr_fall
			&& !data_wr |=> dac_update_o && busy_n_o;
	endproperty
	a_flush: assert property (p_flush) else $error("stored load lost");

	property p_write_a;
		@(posedge mclk_i) disable iff (rst_i)
		data_wr && !toggle && (req.chan == 6'h03) |=> data_a_reg[3] == $past(req.data);
	endproperty
	a_write_a: assert property (p_write_a) else $error("write missed register A");

	property p_sdo;
		@(posedge mclk_i) disable iff (rst_i)
		sclk_rise |=> serial_data_out_o == $past(shift_reg[`FRAME_BITS-1]);
	endproperty
	a_sdo: assert property (p_sdo) else $error("serial out wrong bit");

	c_reset_done: cover property (@(posedge mclk_i) disable iff (rst_i)
		(state_reg == ST_RESET) ##1 (state_reg == ST_IDLE));
	c_clear: cover property (@(posedge mclk_i) disable iff (rst_i)
		clr_fall && (state_reg == ST_IDLE));
	c_deferred: cover property (@(posedge mclk_i) disable iff (rst_i) flush && !load_now);
	c_toggle: cover property (@(posedge mclk_i) disable iff (rst_i) do_update && show_b);

endmodule
`default_nettype wire

// ===== hdl/dac_ctrl_map.svh
// Offsets, field positions, reset values and timing counts for the DAC control block.
// Assumes the single system clock runs at 40 MHz.
`ifndef DAC_CTRL_MAP_SVH
`define DAC_CTRL_MAP_SVH
`define MCLK_MHZ 40
`define NUM_CH 40
`define CLR_TIME_NS 35000
`define RST_TIME_NS 270000
`define CALC_TIME_NS 1000
// Least times round up to whole cycles
`define CLR_CYCLES ((`CLR_TIME_NS * `MCLK_MHZ + 999) / 1000)
`define RST_CYCLES ((`RST_TIME_NS * `MCLK_MHZ + 999) / 1000)
`define CALC_CYCLES ((`CALC_TIME_NS * `MCLK_MHZ + 999) / 1000)
`define FRAME_BITS 24
`define FR_AB 23
`define FR_SEL_HI 19
`define FR_SEL_LO 18
`define FR_CH_HI 17
`define FR_CH_LO 12
`define FR_DAT_HI 11
`define FR_DAT_LO 0
`define SFR_CLRCODE 6'h02
`define DATA_RST 12'h000
`define OFFSET_RST 12'h800
`define GAIN_RST 12'hFFF
`define CLRCODE_RST 12'h000
`endif

// ===== hdl/dac_ctrl_pkg.sv
// Types shared by the DAC update and reset control block.
// Assumes the constants of dac_ctrl_map.svh.
package dac_ctrl_pkg;
	typedef enum logic [1:0] {
		SEL_SFR = 2'h0,
		SEL_GAIN = 2'h1,
		SEL_OFFSET = 2'h2,
		SEL_DATA = 2'h3
	} reg_sel_e;
	typedef enum logic [3:0] {
		ST_RESET = 4'h1,
		ST_IDLE = 4'h2,
		ST_CALC = 4'h4,
		ST_CLEAR = 4'h8
	} state_e;
	typedef logic [11:0] code_t;
	typedef logic [13:0] cnt_t;
	typedef logic [5:0] chan_t;
	typedef struct packed {
		logic ab;
		reg_sel_e sel;
		chan_t chan;
		code_t data;
	} wr_req_s;
	typedef struct packed {
		chan_t addr;
		reg_sel_e sel;
		code_t data;
		logic cs_n;
		logic wr_n;
		logic ser;
		logic ab;
		logic ld_n;
		logic clr_n;
		logic rst_n;
		logic sclk;
		logic sdin;
		logic sync_n;
		logic toggle;
	} pins_s;
endpackage

// ===== verification/host_model.sv
// Host controller model that drives the DAC control pins.
// Assumes the bench calls its tasks; pins change only at falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module host_model
	import dac_ctrl_pkg::*;
(
	// Clock and serial readback
	input wire logic mclk_i,
	input wire logic sdo_i,
	input wire logic oe_n_i,
	// Pins towards the device
	output var pins_s pins_o
);
	// ****************************************
	// Pin sequences
	// ****************************************
	initial begin
		// Strobes, chip select and frame idle high, serial clock low
		pins_o = {20'h00000, 11'h672};
	end

	task automatic idle(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	// Every level is held 4 cycles, since the device samples pins through three flops
	task automatic par_wr(input logic [1:0] sel, input chan_t ch, input logic ab, input code_t d);
		pins_o.sel = reg_sel_e'(sel);
		pins_o.addr = ch;
		pins_o.ab = ab;
		pins_o.data = d;
		pins_o.cs_n = 1'b0;
		idle(4);
		pins_o.wr_n = 1'b0;
		idle(4);
		pins_o.wr_n = 1'b1;
		idle(4);
		pins_o.cs_n = 1'b1;
		// Released bus shows no stale value
		pins_o.data = ~d;
		idle(4);
	endtask

	// Reset pin and toggle mode are levels that the bench sets between tests
	task automatic set_ctrl(input logic rst_n, input logic tog);
		pins_o.rst_n = rst_n;
		pins_o.toggle = tog;
	endtask

	task automatic pulse(input int k);
		pins_o.ld_n = (k != 0);
		pins_o.clr_n = (k == 0);
		idle(4);
		pins_o.ld_n = 1'b1;
		pins_o.clr_n = 1'b1;
		idle(4);
	endtask

	task automatic frame(input logic [23:0] f, output logic [23:0] got, output logic oe);
		int i;
		pins_o.ser = 1'b1;
		pins_o.sync_n = 1'b0;
		idle(4);
		for (i = 23; i >= 0; i--) begin
			pins_o.sdin = f[i];
			pins_o.sclk = ~pins_o.sclk;
			idle(4);
			got[i] = sdo_i;
			pins_o.sclk = ~pins_o.sclk;
			idle(4);
		end
		oe = oe_n_i;
		pins_o.sync_n = 1'b1;
		idle(4);
		pins_o.ser = 1'b0;
		pins_o.sdin = ~pins_o.sdin;
	endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the DAC update, clear and reset control.
// Assumes host_model drives all pins; reset sequence shortened to 16 cycles.
`include "dac_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench
	import dac_ctrl_pkg::*;
;
	localparam int RST_CYC = 16;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	pins_s pins;
	logic serial_data_out, oe_n, busy_n, upd, oe;
	code_t [`NUM_CH-1:0] dac;
	int n_errors = 0;
	int samples_checked = 0;
	int n_upd = 0;
	integer seed = 32'he21d;
	logic [23:0] got, f1;
	chan_t c;
	code_t d, d2;
	int i, t;

	always #12.5 mclk_i = ~mclk_i;
	always @(negedge mclk_i) if (upd === 1'b1) n_upd <= n_upd + 1;

	host_model host (.mclk_i(mclk_i), .sdo_i(serial_data_out), .oe_n_i(oe_n), .pins_o(pins));
	dac_update_and_reset_control #(.RESET_CYCLES(RST_CYC)) dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .channel_address_i(pins.addr),
		.register_select_i(pins.sel), .data_i(pins.data), .cs_n_i(pins.cs_n),
		.wr_n_i(pins.wr_n), .ser_par_i(pins.ser), .ab_select_i(pins.ab),
		.toggle_mode_i(pins.toggle), .load_outputs_strobe_n_i(pins.ld_n),
		.clear_input_n_i(pins.clr_n), .reset_n_i(pins.rst_n), .sclk_i(pins.sclk),
		.sdin_i(pins.sdin), .sync_n_i(pins.sync_n), .serial_data_out_o(serial_data_out),
		.serial_data_out_oe_n_o(oe_n), .busy_n_o(busy_n), .dac_update_o(upd), .dac_out_o(dac));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic chan_t pick_ch();
		return chan_t'($unsigned($random(seed)) % `NUM_CH);
	endfunction

	function automatic logic [23:0] frame_of(logic [1:0] sel, chan_t ch, code_t v);
		return {4'h0, sel, ch, v};
	endfunction

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_busy(input logic lvl, input int lim);
		int k;
		k = 0;
		while (busy_n !== lvl && k < lim) begin
			@(negedge mclk_i);
			k++;
		end
		chk("busy_n", {23'h0, lvl}, {23'h0, busy_n});
	endtask

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Whole run needs about 3000 cycles
	initial begin
		repeat (10000) @(posedge mclk_i);
		n_errors++;
		stop_test();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (2) @(negedge mclk_i);
		rst_i = 1'b0;
		@(negedge mclk_i);
		chk("busy_n in reset", 24'h0, {23'h0, busy_n});
		wait_busy(1'b1, RST_CYC + 4);
		$display("test power-on done");
		for (i = 0; i < 4; i++) begin
			c = pick_ch();
			d = code_t'($random(seed));
			d2 = code_t'($random(seed));
			t = n_upd;
			host.par_wr(2'h3, c, 1'b1, d);
			chk("busy_n calc", 24'h0, {23'h0, busy_n});
			host.pulse(0);
			chk("update in calc", 24'(t), 24'(n_upd));
			host.par_wr(2'h1, c, 1'b0, ~d);
			host.par_wr(2'h2, c, 1'b0, d2);
			chk("stored load", 24'(t + 1), 24'(n_upd));
			chk("dac", {12'h0, d}, {12'h0, dac[c]});
			host.par_wr(2'h3, c, 1'b0, d2);
			wait_busy(1'b1, 60);
			host.pulse(0);
			chk("dac idle load", {12'h0, d2}, {12'h0, dac[c]});
		end
		$display("test writes and loads done");
		d = code_t'($random(seed));
		host.par_wr(2'h0, `SFR_CLRCODE, 1'b0, d);
		host.pulse(1);
		for (i = 0; i < `NUM_CH; i++) chk("dac clear", {12'h0, d}, {12'h0, dac[i]});
		host.idle(1385);
		chk("busy_n clear", 24'h0, {23'h0, busy_n});
		wait_busy(1'b1, 30);
		host.par_wr(2'h3, 6'h2F, 1'b0, 12'h123);
		chk("busy_n bad channel", 24'h1, {23'h0, busy_n});
		$display("test clear done");
		c = pick_ch();
		host.par_wr(2'h3, c, 1'b0, 12'hABC);
		host.pulse(0);
		t = n_upd;
		host.set_ctrl(1'b0, 1'b0);
		host.pulse(0);
		wait_busy(1'b1, RST_CYC + 4);
		host.idle(60);
		chk("busy_n pin held", 24'h1, {23'h0, busy_n});
		chk("load after reset", 24'(t), 24'(n_upd));
		chk("dac after reset", 24'h0, {12'h0, dac[c]});
		$display("test reset pin done");
		host.set_ctrl(1'b1, 1'b1);
		d = code_t'($random(seed));
		d2 = ~d;
		host.par_wr(2'h3, c, 1'b0, d);
		host.par_wr(2'h3, c, 1'b1, d2);
		wait_busy(1'b1, 60);
		for (i = 0; i < 3; i++) begin
			host.pulse(0);
			chk("dac toggle", {12'h0, (i == 1) ? d2 : d}, {12'h0, dac[c]});
		end
		host.set_ctrl(1'b1, 1'b0);
		$display("test toggle done");
		c = pick_ch();
		d = code_t'($random(seed));
		f1 = frame_of(2'h3, c, d);
		host.frame(f1, got, oe);
		chk("sdo enable", 24'h0, {23'h0, oe});
		wait_busy(1'b1, 60);
		host.pulse(0);
		chk("dac serial", {12'h0, d}, {12'h0, dac[c]});
		host.frame(frame_of(2'h1, pick_ch(), 12'h5A5), got, oe);
		chk("sdo readback", f1, got);
		chk("sdo enable idle", 24'h1, {23'h0, oe_n});
		$display("test serial done");
		stop_test();
	end
endmodule
`default_nettype wire
